// ===== hw/wdt_defs.vh
// register offsets, field positions, keys and timing constants for the watchdog block
`ifndef WTC_DEFS_VH
`define WTC_DEFS_VH
`define WTC_OFF_CNTCTL 12'h000
`define WTC_OFF_RSTCTL 12'h004
`define WTC_OFF_READ 12'h008
`define WTC_OFF_IRQ_STATUS 12'h00c
`define WTC_OFF_IRQ_MASK 12'h010
`define WTC_KEY_CNT 8'h5a
`define WTC_KEY_CTL 8'ha5
`define WTC_KEY_RSTCFG 8'h5a
`define WTC_KEY_FLAGCLR 8'ha5
`define WTC_BIT_FLAG 7
`define WTC_BIT_MODE 6
`define WTC_BIT_EN 5
`define WTC_BIT_RSTEN 6
`define WTC_BIT_RSTTYPE 5
`define WTC_RST_LANE 16
`define WTC_CTL_RSVD 8'h18
`define WTC_RST_RSVD 8'h1f
`define WTC_ZERO8 8'h00
`define WTC_MAX8 8'hff
`define WTC_IRQ_ITV 0
`define WTC_IRQ_WDG 1
`define WTC_OVF_OUT_NS 640
`define WTC_RST_OUT_NS 2560
`define WTC_CLK_NS 5
`endif

// ===== hw/wdt_prescaler.v
// free-running divider that turns the selected ratio into a one-cycle tick enable
`timescale 1ns/10ps
`default_nettype none
module wtc_prescaler #(
  parameter WIDTH = 13
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire run,
  input wire [2:0] sel,
  // tick
  output reg tick
);
  reg [WIDTH-1:0] div;
  reg [WIDTH-1:0] prev;

  // ratio code to the divider bit whose rising transition marks one period
  function integer wtc_tap;
    input [2:0] code;
    begin
      case (code)
        3'h0: wtc_tap = 0;
        3'h1: wtc_tap = 5;
        3'h2: wtc_tap = 6;
        3'h3: wtc_tap = 7;
        3'h4: wtc_tap = 8;
        3'h5: wtc_tap = 9;
        3'h6: wtc_tap = 11;
        default: wtc_tap = 12;
      endcase
    end
  endfunction

  wire [WIDTH-1:0] next_div = div + {{(WIDTH-1){1'b0}}, 1'b1};

  // divider restarts while stopped, so the first tick comes after half a period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= {WIDTH{1'b0}};
      prev <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (!run) begin
      div <= {WIDTH{1'b0}};
      prev <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else begin
      div <= next_div;
      prev <= div;
      tick <= div[wtc_tap(sel)] & ~prev[wtc_tap(sel)];
    end
  end
endmodule // wtc_prescaler
`default_nettype wire

// ===== hw/wdt_timer.v
// watchdog / interval timer with keyed apb register access and reset request outputs
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.vh"
// Functional notes
// - mode bit picks interval interrupt or watchdog pin
// - disabled timer holds counter at zero
// - enabled counter counts ticks, overflow signals by mode
// - control bits four and three read one
// - divider codes give ratios 2 to 8192
// - watchdog overflow flag set only in watchdog mode
// - watchdog flag cleared by read-one-then-write-zero
// - no reset enable: clear counter and control
// - reset enable requests internal chip reset
// - reset type: zero power-on, one manual
// - reset control bits four to zero read one
// - control and reset config bits reset zero
// - eight-bit counter overflows on ff to 00
// - interval flag set, cleared by zero-write or disable
// - keyed word write loads counter or control
// - keyed reset-control write clears flag or loads config
module wtc_timer #(
  parameter CNT_W = 8,
  parameter OVF_OUT_CYC = `WTC_OVF_OUT_NS / `WTC_CLK_NS,
  parameter RST_OUT_CYC = `WTC_RST_OUT_NS / `WTC_CLK_NS
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // outputs
  output reg overflow_output_pin_n,
  output wire interval_interrupt,
  output reg poweron_reset_req,
  output reg manual_reset_req,
  output wire irq
);
  reg [CNT_W-1:0] tick_counter;
  reg timer_mode_select;
  reg count_enable_bit;
  reg [2:0] clk_sel;
  reg interval_overflow_flag;
  reg watchdog_overflow_flag;
  reg reset_on_overflow_enable;
  reg reset_type_select;
  reg ovf_seen_one;
  reg wdg_seen_one;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg [7:0] ovf_cnt;
  reg [9:0] rst_cnt;
  wire tick;

  wtc_prescaler #(.WIDTH(13)) u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(count_enable_bit),
    .sel(clk_sel),
    .tick(tick)
  );

  // bus decode; zero wait states, no error answer
  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  wire [7:0] key = pwdata[15:8];
  wire [7:0] lo = pwdata[7:0];
  wire wr_cntctl = wr && paddr == `WTC_OFF_CNTCTL;
  wire wr_rstctl = wr && paddr == `WTC_OFF_RSTCTL;
  wire rd_read = rd && paddr == `WTC_OFF_READ;
  wire rd_status = rd && paddr == `WTC_OFF_IRQ_STATUS;
  wire wr_cnt = wr_cntctl && key == `WTC_KEY_CNT;
  wire wr_ctl = wr_cntctl && key == `WTC_KEY_CTL;
  wire wr_cfg = wr_rstctl && key == `WTC_KEY_RSTCFG;
  wire wr_wclr = wr_rstctl && key == `WTC_KEY_FLAGCLR && lo == `WTC_ZERO8;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // one pulse per wrap, since a tick lasts one cycle
  wire wrap = count_enable_bit & tick & (tick_counter == {CNT_W{1'b1}}) & ~wr_cnt;
  wire wdg_evt = wrap & timer_mode_select;
  wire itv_evt = wrap & ~timer_mode_select;
  // watchdog overflow without chip reset still clears counter and control
  wire wdg_self_clear = wdg_evt & ~reset_on_overflow_enable;

  wire [7:0] ctl_rd = {interval_overflow_flag, timer_mode_select, count_enable_bit, 2'b11, clk_sel};
  wire [7:0] rst_rd = {watchdog_overflow_flag, reset_on_overflow_enable, reset_type_select, 5'h1f};

  // counter; a counter write beats a tick in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_counter <= {CNT_W{1'b0}};
    end else if (!count_enable_bit || wdg_self_clear) begin
      tick_counter <= {CNT_W{1'b0}};
    end else if (wr_cnt) begin
      tick_counter <= lo[CNT_W-1:0];
    end else if (tick) begin
      tick_counter <= tick_counter + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // timer control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_select <= 1'b0;
      count_enable_bit <= 1'b0;
      clk_sel <= 3'h0;
    end else if (wdg_self_clear) begin
      timer_mode_select <= 1'b0;
      count_enable_bit <= 1'b0;
      clk_sel <= 3'h0;
    end else if (wr_ctl) begin
      timer_mode_select <= lo[`WTC_BIT_MODE];
      count_enable_bit <= lo[`WTC_BIT_EN];
      clk_sel <= lo[2:0];
    end
  end

  // interval flag; a set in the same cycle beats any clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_overflow_flag <= 1'b0;
      ovf_seen_one <= 1'b0;
    end else begin
      // judge by the word software got, not a flag set after the capture
      if (rd_read && prdata[`WTC_BIT_FLAG]) begin
        ovf_seen_one <= 1'b1;
      end else if (wr_ctl) begin
        ovf_seen_one <= 1'b0;
      end
      if (itv_evt) begin
        interval_overflow_flag <= 1'b1;
      end else if (wdg_self_clear) begin
        interval_overflow_flag <= 1'b0;
      end else if (wr_ctl && !lo[`WTC_BIT_FLAG] && ovf_seen_one) begin
        interval_overflow_flag <= 1'b0;
      end else if (wr_ctl && !lo[`WTC_BIT_EN] && !timer_mode_select) begin
        interval_overflow_flag <= 1'b0;
      end
    end
  end

  // reset control; writing one to the flag does nothing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_overflow_flag <= 1'b0;
      wdg_seen_one <= 1'b0;
      reset_on_overflow_enable <= 1'b0;
      reset_type_select <= 1'b0;
    end else begin
      if (rd_read && prdata[`WTC_RST_LANE + `WTC_BIT_FLAG]) begin
        wdg_seen_one <= 1'b1;
      end else if (wr_wclr) begin
        wdg_seen_one <= 1'b0;
      end
      if (wdg_evt) begin
        watchdog_overflow_flag <= 1'b1;
      end else if (wr_wclr && wdg_seen_one) begin
        watchdog_overflow_flag <= 1'b0;
      end
      if (wr_cfg) begin
        reset_on_overflow_enable <= lo[`WTC_BIT_RSTEN];
        reset_type_select <= lo[`WTC_BIT_RSTTYPE];
      end
    end
  end

  // pulse stretchers for the pin and the reset requests
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_cnt <= 8'h00;
      rst_cnt <= 10'h000;
      overflow_output_pin_n <= 1'b1;
      poweron_reset_req <= 1'b0;
      manual_reset_req <= 1'b0;
    end else begin
      if (wdg_evt) begin
        ovf_cnt <= OVF_OUT_CYC[7:0];
        overflow_output_pin_n <= 1'b0;
      end else if (ovf_cnt != 8'h00) begin
        ovf_cnt <= ovf_cnt - 8'h01;
        overflow_output_pin_n <= (ovf_cnt == 8'h01);
      end
      if (wdg_evt && reset_on_overflow_enable) begin
        rst_cnt <= RST_OUT_CYC[9:0];
        poweron_reset_req <= ~reset_type_select;
        manual_reset_req <= reset_type_select;
      end else if (rst_cnt != 10'h000) begin
        rst_cnt <= rst_cnt - 10'h001;
        if (rst_cnt == 10'h001) begin
          poweron_reset_req <= 1'b0;
          manual_reset_req <= 1'b0;
        end
      end
    end
  end

  // interval request follows the flag
  assign interval_interrupt = interval_overflow_flag;

  // sticky event status, cleared by reading it; set wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 2'b00;
      irq_mask <= 2'b00;
    end else begin
      // clear only what the captured word reported, so a late event survives
      irq_status <= (irq_status & ~(rd_status ? prdata[1:0] : 2'b00)) | {wdg_evt, itv_evt};
      if (wr && paddr == `WTC_OFF_IRQ_MASK) begin
        irq_mask <= pwdata[1:0];
      end
    end
  end
  assign irq = |(irq_status & irq_mask);

  // read data registered during setup so it is valid in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      case (paddr)
        `WTC_OFF_READ: prdata <= {8'h00, rst_rd, tick_counter, ctl_rd};
        `WTC_OFF_IRQ_STATUS: prdata <= {30'h0, irq_status};
        `WTC_OFF_IRQ_MASK: prdata <= {30'h0, irq_mask};
        default: prdata <= 32'h0;
      endcase
    end
  end
endmodule // wtc_timer
`default_nettype wire

// ===== bench/wtc_timer_sva.sv
// port assertions for the watchdog timer
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.vh"
module wtc_timer_sva #(
  parameter OVF_OUT_CYC = 128,
  parameter RST_OUT_CYC = 512
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire overflow_output_pin_n,
  input wire interval_interrupt,
  input wire poweron_reset_req,
  input wire manual_reset_req
);
  wire req = poweron_reset_req | manual_reset_req;
  reg [15:0] low_n;
  reg [15:0] req_n;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // run-length counters; sixteen bits cover any run below 65536 cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_n <= 16'h0000;
      req_n <= 16'h0000;
    end else begin
      low_n <= overflow_output_pin_n ? 16'h0000 : low_n + 16'h0001;
      req_n <= req ? req_n + 16'h0001 : 16'h0000;
    end
  end
  pin_len_a: assert property ($rose(overflow_output_pin_n) |-> low_n == OVF_OUT_CYC) else $error("pin pulse");
  pin_cap_a: assert property (low_n <= OVF_OUT_CYC) else $error("pin too long");
  req_len_a: assert property ($fell(req) |-> req_n == RST_OUT_CYC) else $error("req pulse");
  req_one_a: assert property (!(poweron_reset_req && manual_reset_req)) else $error("two reqs");
  req_sync_a: assert property ($rose(req) |-> $fell(overflow_output_pin_n)) else $error("req not with pin");
  itv_mode_a: assert property ($rose(interval_interrupt) |-> overflow_output_pin_n) else $error("both modes");
  itv_clr_a: assert property ($fell(interval_interrupt) |-> $past(psel && penable && pwrite)) else $error("flag lost");
  rsvd_one_a: assert property (psel && penable && !pwrite && paddr == `WTC_OFF_READ
    |-> prdata[4:3] == 2'b11 && prdata[20:16] == 5'h1f) else $error("reserved bits");
  cover property ($rose(interval_interrupt));
  cover property ($rose(poweron_reset_req));
  cover property ($rose(manual_reset_req));
endmodule // wtc_timer_sva
bind wtc_timer wtc_timer_sva #(.OVF_OUT_CYC(OVF_OUT_CYC), .RST_OUT_CYC(RST_OUT_CYC)) i_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .overflow_output_pin_n(overflow_output_pin_n), .interval_interrupt(interval_interrupt),
  .poweron_reset_req(poweron_reset_req), .manual_reset_req(manual_reset_req));
`default_nettype wire

// ===== bench/watchdog_interval_timer_control_bench.sv
// self-checking bench for the watchdog timer
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.vh"
module watchdog_interval_timer_control_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mode_w = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, pin_n, itv, por, man, irq;
  int failures = 0, check_count = 0, n, k;
  int dv[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
  logic [7:0] cf[3] = '{8'h1f, 8'h5f, 8'h7f};
  // short pulses keep the run brief
  wtc_timer #(.OVF_OUT_CYC(8), .RST_OUT_CYC(16)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .overflow_output_pin_n(pin_n), .interval_interrupt(itv),
    .poweron_reset_req(por), .manual_reset_req(man), .irq(irq));
  wire ev = mode_w ? pin_n === 1'b0 : itv === 1'b1;
  initial forever #2.5 pclk = ~pclk;
  task automatic give_verdict;
    $display("failures=%0d checks=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_ev(input int lim);
    n = 0;
    while (!ev) begin
      @(posedge pclk);
      n++;
      if (n > lim) begin
        failures++;
        give_verdict();
      end
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      if (++i > 50) begin
        failures++;
        give_verdict();
      end
      @(posedge pclk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    void'($urandom(36399));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk({pready, pslverr, por, man, pin_n, itv, irq}, 7'h44);
    apb(0, `WTC_OFF_READ, 0);
    chk(rd[23:0], 24'h1f0018);
    apb(1, `WTC_OFF_IRQ_MASK, 32'h1);
    apb(0, `WTC_OFF_IRQ_MASK, 0);
    chk(rd, 32'h1);
    for (k = 0; k < 8; k++) begin
      apb(1, `WTC_OFF_CNTCTL, {16'h0, `WTC_KEY_CTL, 5'h07, k[2:0]});
      apb(1, `WTC_OFF_CNTCTL, {16'h0, `WTC_KEY_CNT, `WTC_MAX8});
      wait_ev(20000);
      chk(n + 2 > dv[k] / 2 && n <= dv[k] + 4, 1);
      chk(irq, 1);
      apb(0, `WTC_OFF_IRQ_STATUS, 0);
      chk(rd[1:0], 2'b01);
      apb(0, `WTC_OFF_READ, 0);
      chk(rd[7:0], {5'h17, k[2:0]});
      apb(1, `WTC_OFF_CNTCTL, {16'h0, `WTC_KEY_CTL, 5'h03, k[2:0]});
      apb(0, `WTC_OFF_READ, 0);
      chk({itv, irq, rd[15:0]}, {2'b00, 8'h00, 5'h03, k[2:0]});
    end
    // wrong keys on the counter/control word must leave counter and control alone
    repeat (4) begin
      apb(1, `WTC_OFF_CNTCTL, {16'h0, 8'($urandom & 8'h3f), 8'h3f});
      apb(0, `WTC_OFF_READ, 0);
      chk(rd[15:0], 16'h001f);
    end
    mode_w = 1'b1;
    for (k = 0; k < 3; k++) begin
      apb(1, `WTC_OFF_RSTCTL, {16'h0, `WTC_KEY_RSTCFG, cf[k]});
      apb(1, `WTC_OFF_CNTCTL, {16'h0, `WTC_KEY_CTL, 8'h78});
      apb(1, `WTC_OFF_CNTCTL, {16'h0, `WTC_KEY_CNT, `WTC_MAX8});
      wait_ev(100);
      chk({por, man, itv, irq}, {k == 1, k == 2, 2'b00});
      apb(1, `WTC_OFF_RSTCTL, {16'h0, `WTC_KEY_FLAGCLR, 8'h80});
      apb(0, `WTC_OFF_READ, 0);
      chk({rd[23:16], rd[7:0]}, {1'b1, cf[k][6:0], k ? 8'h78 : 8'h18});
      apb(1, `WTC_OFF_RSTCTL, {16'h0, `WTC_KEY_FLAGCLR, `WTC_ZERO8});
      apb(0, `WTC_OFF_READ, 0);
      chk(rd[23:16], {1'b0, cf[k][6:0]});
      apb(1, `WTC_OFF_CNTCTL, {16'h0, `WTC_KEY_CTL, 8'h58});
      repeat (20) @(posedge pclk);
    end
    give_verdict();
  end
endmodule // watchdog_interval_timer_control_bench
`default_nettype wire
